// *** hw/asr_pkg.sv ***
// package for the asynchronous serial channel, transmitter and receiver
// assumes one 10 MHz clock and a plain address/strobe register port
package asr_pkg;
  localparam int CLK_HZ = 10_000_000;
  // register addresses as printed, plus added ones
  localparam logic [31:0] ADDR_MODE = 32'hFFFE8000;
  localparam logic [31:0] ADDR_BAUD = 32'hFFFE8002;
  localparam logic [31:0] ADDR_CTRL = 32'hFFFE8004;
  localparam logic [31:0] ADDR_TXD = 32'hFFFE8006;
  localparam logic [31:0] ADDR_STAT = 32'hFFFE8008;
  localparam logic [31:0] ADDR_RXD = 32'hFFFE800A;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'hFFFE800C;
  localparam logic [31:0] ADDR_IRQ_EN = 32'hFFFE800E;
  localparam logic [31:0] ADDR_IRQ_CLR = 32'hFFFE8010;
  localparam logic [31:0] ADDR_HALT = 32'hFFFE8012;
  // mode register fields
  localparam int MODE_CHAR_LEN = 6;
  localparam int MODE_PARITY_ON = 5;
  localparam int MODE_ODD = 4;
  localparam int MODE_STOP = 3;
  localparam int MODE_PRESCALE = 0;
  // control register fields
  localparam int CTRL_TX_EMPTY_IRQ_EN = 7;
  localparam int CTRL_RX_IRQ_EN = 6;
  localparam int CTRL_TX_ON = 5;
  localparam int CTRL_RX_ON = 4;
  localparam int CTRL_CKE = 0;
  // status register fields
  localparam int ST_TX_BUF_EMPTY = 7;
  localparam int ST_RDRF = 6;
  localparam int ST_ORER = 5;
  localparam int ST_FER = 4;
  localparam int ST_PER = 3;
  localparam int ST_TX_DONE = 2;
  // interrupt status bits
  localparam int IRQ_TXE = 0;
  localparam int IRQ_RXF = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h84;
  localparam logic HALT_RST = 1'b1;
  // oversampling and bit counts, clock source codes
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [2:0] BITS8_LAST = 3'h7;
  localparam logic [2:0] BITS7_LAST = 3'h6;
  localparam logic [1:0] CKE_INT = 2'h0;
  localparam logic [1:0] CKE_OUT = 2'h1;

  typedef enum logic [2:0] {
    LN_IDLE, LN_START, LN_DATA, LN_PAR, LN_STOP
  } asr_line_st_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asr_bus_req_t;
endpackage

// *** hw/asr_sync.sv ***
// two-flop synchroniser for one level
// assumes the input is asynchronous to sys_clk_i
`timescale 1ns/1ps
module asr_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } asr_sync_st_t;
  asr_sync_st_t st_reg;
  asr_sync_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule

// *** hw/asr_baud.sv ***
// baud generator: one-cycle tick at sixteen times the bit rate
// assumes divisor and prescale are steady while enabled
`timescale 1ns/1ps
module asr_baud (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [7:0] div_i,
  input wire logic [1:0] prescale_i,
  output logic tick_o
);
  import asr_pkg::*;
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } asr_baud_st_t;
  asr_baud_st_t st_reg;
  asr_baud_st_t st_next;
  logic [15:0] lim;

  always_comb begin
    // period 2*(div+1)*4^prescale cycles per tick
    lim = (({8'h00, div_i} + 16'h0001) << {prescale_i, 1'b1}) - 16'h0001;
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!en_i) begin
      st_next.cnt = 16'h0000;
    end else if (st_reg.cnt >= lim) begin
      st_next.cnt = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;
endmodule

// *** hw/asr_top.sv ***
// asynchronous serial channel: registers, transmitter, receiver, irq
// assumes rxd_i is asynchronous and the bus master never waits
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module asr_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire asr_pkg::asr_bus_req_t bus_i,
  output logic [7:0] rd_data_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic sck_o,
  output logic sck_oe_o,
  output logic tx_empty_irq_o,
  output logic rx_full_irq_o,
  output logic rx_error_irq_o,
  output logic irq_o
);
  import asr_pkg::*;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] baud;
    logic [7:0] ctrl;
    logic [7:0] tdr;
    logic [7:0] rdr;
    logic tx_buf_empty_flag;
    logic rdrf;
    logic orer;
    logic fer;
    logic per;
    logic tx_done_flag;
    logic halt;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [7:0] rd_data;
    asr_line_st_t tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [2:0] tx_bit;
    logic txd;
    asr_line_st_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic rx_perr;
    logic rxd_prev;
    logic tx_empty_irq;
    logic rx_full_irq;
    logic rx_error_irq;
    logic irq;
    logic sck;
    logic sck_oe;
  } asr_top_st_t;

  asr_top_st_t st_reg;
  asr_top_st_t st_next;
  logic tick;
  logic rxd_s;
  logic run;
  logic [2:0] last_bit;
  logic [7:0] stat_val;
  logic [IRQ_W-1:0] irq_set;

  assign run = ~st_reg.halt;

  asr_sync #(
    .RST_VAL(1'b1)
  ) u_rx_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(rxd_i),
    .q_o(rxd_s)
  );

  asr_baud u_baud (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .en_i(run),
    .div_i(st_reg.baud),
    .prescale_i(st_reg.mode[MODE_PRESCALE +: 2]),
    .tick_o(tick)
  );

  always_comb begin
    st_next = st_reg;
    irq_set = '0;
    last_bit = st_reg.mode[MODE_CHAR_LEN] ? BITS7_LAST : BITS8_LAST;
    stat_val = {st_reg.tx_buf_empty_flag, st_reg.rdrf, st_reg.orer,
                st_reg.fer, st_reg.per, st_reg.tx_done_flag, 2'b00};

    // register reads: data only in the cycle after the strobe
    st_next.rd_data = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_MODE: st_next.rd_data = st_reg.mode;
        ADDR_BAUD: st_next.rd_data = st_reg.baud;
        ADDR_CTRL: st_next.rd_data = st_reg.ctrl;
        ADDR_TXD: st_next.rd_data = st_reg.tdr;
        ADDR_STAT: st_next.rd_data = stat_val;
        ADDR_RXD: st_next.rd_data = st_reg.rdr;
        ADDR_IRQ_STAT: st_next.rd_data = {5'h00, st_reg.irq_stat};
        ADDR_IRQ_EN: st_next.rd_data = {5'h00, st_reg.irq_en};
        ADDR_HALT: st_next.rd_data = {7'h00, st_reg.halt};
        default: st_next.rd_data = 8'h00;
      endcase
    end

    // register writes; hardware sets below override clears
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        ADDR_MODE: st_next.mode = bus_i.wdata;
        ADDR_BAUD: st_next.baud = bus_i.wdata;
        ADDR_CTRL: st_next.ctrl = bus_i.wdata;
        ADDR_TXD: begin
          st_next.tdr = bus_i.wdata;
          st_next.tx_buf_empty_flag = 1'b0;
          st_next.tx_done_flag = 1'b0;
        end
        ADDR_STAT: begin
          // write zero to clear receive flags
          st_next.rdrf = st_reg.rdrf & bus_i.wdata[ST_RDRF];
          st_next.orer = st_reg.orer & bus_i.wdata[ST_ORER];
          st_next.fer = st_reg.fer & bus_i.wdata[ST_FER];
          st_next.per = st_reg.per & bus_i.wdata[ST_PER];
        end
        ADDR_IRQ_EN: st_next.irq_en = bus_i.wdata[IRQ_W-1:0];
        ADDR_IRQ_CLR: begin
          st_next.irq_stat = st_reg.irq_stat & ~bus_i.wdata[IRQ_W-1:0];
        end
        ADDR_HALT: st_next.halt = bus_i.wdata[0];
        default: begin
        end
      endcase
    end

    // transmitter
    if (!run || !st_reg.ctrl[CTRL_TX_ON]) begin
      st_next.tx_st = LN_IDLE;
      st_next.txd = 1'b1;
    end else begin
      unique case (st_reg.tx_st)
        LN_IDLE: begin
          st_next.txd = 1'b1;
          if (!st_reg.tx_buf_empty_flag && tick) begin
            st_next.tx_sh = st_reg.tdr;
            st_next.tx_buf_empty_flag = 1'b1;
            irq_set[IRQ_TXE] = 1'b1;
            st_next.tx_done_flag = 1'b0;
            st_next.tx_cnt = 4'h0;
            st_next.tx_st = LN_START;
            st_next.txd = 1'b0;
          end
        end
        default: begin
          if (tick) begin
            st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
            if (st_reg.tx_cnt == TICK_LAST) begin
              unique case (st_reg.tx_st)
                LN_START: begin
                  st_next.tx_st = LN_DATA;
                  st_next.tx_bit = 3'h0;
                  st_next.txd = st_reg.tx_sh[0];
                end
                LN_DATA: begin
                  if (st_reg.tx_bit == last_bit) begin
                    if (st_reg.mode[MODE_PARITY_ON]) begin
                      st_next.tx_st = LN_PAR;
                      st_next.txd = (^(st_reg.tx_sh
                                     & {~st_reg.mode[MODE_CHAR_LEN], 7'h7F}))
                                    ^ st_reg.mode[MODE_ODD];
                    end else begin
                      st_next.tx_st = LN_STOP;
                      st_next.tx_bit = 3'h0;
                      st_next.txd = 1'b1;
                    end
                  end else begin
                    st_next.tx_bit = st_reg.tx_bit + 3'h1;
                    st_next.txd = st_reg.tx_sh[st_reg.tx_bit + 3'h1];
                  end
                end
                LN_PAR: begin
                  st_next.tx_st = LN_STOP;
                  st_next.tx_bit = 3'h0;
                  st_next.txd = 1'b1;
                end
                LN_STOP: begin
                  if (st_reg.mode[MODE_STOP] && st_reg.tx_bit == 3'h0) begin
                    st_next.tx_bit = 3'h1;
                  end else begin
                    st_next.tx_st = LN_IDLE;
                    st_next.tx_done_flag = st_reg.tx_buf_empty_flag;
                  end
                end
                default: st_next.tx_st = LN_IDLE;
              endcase
            end
          end
        end
      endcase
    end

    // receiver
    st_next.rxd_prev = rxd_s;
    if (!run || !st_reg.ctrl[CTRL_RX_ON]) begin
      st_next.rx_st = LN_IDLE;
    end else begin
      unique case (st_reg.rx_st)
        LN_IDLE: begin
          if (st_reg.rxd_prev && !rxd_s) begin
            st_next.rx_st = LN_START;
            st_next.rx_cnt = 4'h0;
            st_next.rx_sh = 8'h00;
            st_next.rx_perr = 1'b0;
          end
        end
        default: begin
          if (tick) begin
            st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
            unique case (st_reg.rx_st)
              LN_START: begin
                if (st_reg.rx_cnt == TICK_MID) begin
                  st_next.rx_cnt = 4'h0;
                  st_next.rx_bit = 3'h0;
                  st_next.rx_st = rxd_s ? LN_IDLE : LN_DATA;
                end
              end
              LN_DATA: begin
                if (st_reg.rx_cnt == TICK_LAST) begin
                  st_next.rx_sh[st_reg.rx_bit] = rxd_s;
                  st_next.rx_bit = st_reg.rx_bit + 3'h1;
                  if (st_reg.rx_bit == last_bit) begin
                    st_next.rx_st = st_reg.mode[MODE_PARITY_ON] ? LN_PAR
                                                        : LN_STOP;
                  end
                end
              end
              LN_PAR: begin
                if (st_reg.rx_cnt == TICK_LAST) begin
                  st_next.rx_perr = rxd_s ^ (^st_reg.rx_sh)
                                    ^ st_reg.mode[MODE_ODD];
                  st_next.rx_st = LN_STOP;
                end
              end
              LN_STOP: begin
                if (st_reg.rx_cnt == TICK_LAST) begin
                  st_next.rx_st = LN_IDLE;
                  if (st_reg.rdrf) begin
                    st_next.orer = 1'b1;
                    irq_set[IRQ_ERR] = 1'b1;
                  end else begin
                    st_next.rdr = st_reg.rx_sh;
                    st_next.rdrf = 1'b1;
                    irq_set[IRQ_RXF] = 1'b1;
                  end
                  // break shows as framing error with zero data
                  if (!rxd_s) begin
                    st_next.fer = 1'b1;
                    irq_set[IRQ_ERR] = 1'b1;
                  end
                  if (st_reg.rx_perr) begin
                    st_next.per = 1'b1;
                    irq_set[IRQ_ERR] = 1'b1;
                  end
                end
              end
              default: st_next.rx_st = LN_IDLE;
            endcase
          end
        end
      endcase
    end

    // sticky interrupt status, set wins over clear
    st_next.irq_stat = st_next.irq_stat | irq_set;
    st_next.irq = |(st_next.irq_stat & st_next.irq_en);

    // per-source request levels
    st_next.tx_empty_irq = st_next.ctrl[CTRL_TX_EMPTY_IRQ_EN]
                           & st_next.tx_buf_empty_flag;
    st_next.rx_full_irq = st_next.ctrl[CTRL_RX_IRQ_EN] & st_next.rdrf;
    st_next.rx_error_irq = st_next.ctrl[CTRL_RX_IRQ_EN]
                           & (st_next.orer | st_next.fer | st_next.per);

    // clock pin stays an input for the internal source
    st_next.sck_oe = run && st_reg.ctrl[CTRL_CKE +: 2] == CKE_OUT;
    st_next.sck = st_reg.tx_cnt[3];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.mode <= MODE_RST;
      st_reg.baud <= BAUD_RST;
      st_reg.ctrl <= CTRL_RST;
      st_reg.tx_buf_empty_flag <= STAT_RST[ST_TX_BUF_EMPTY];
      st_reg.rdrf <= STAT_RST[ST_RDRF];
      st_reg.orer <= STAT_RST[ST_ORER];
      st_reg.fer <= STAT_RST[ST_FER];
      st_reg.per <= STAT_RST[ST_PER];
      st_reg.tx_done_flag <= STAT_RST[ST_TX_DONE];
      st_reg.halt <= HALT_RST;
      st_reg.tx_st <= LN_IDLE;
      st_reg.rx_st <= LN_IDLE;
      st_reg.txd <= 1'b1;
      st_reg.rxd_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_o = st_reg.rd_data;
  assign txd_o = st_reg.txd;
  assign sck_o = st_reg.sck;
  assign sck_oe_o = st_reg.sck_oe;
  assign tx_empty_irq_o = st_reg.tx_empty_irq;
  assign rx_full_irq_o = st_reg.rx_full_irq;
  assign rx_error_irq_o = st_reg.rx_error_irq;
  assign irq_o = st_reg.irq;
endmodule

// *** test/asr_top_assertions.sv ***
// checker: port-level assertions for asr_top
// assumes a bus master that never writes and reads at once
`timescale 1ns/1ps
module asr_top_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire asr_pkg::asr_bus_req_t bus_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic tx_empty_irq_o,
  input wire logic rx_full_irq_o,
  input wire logic rx_error_irq_o,
  input wire logic irq_o
);
  import asr_pkg::*;
  logic [7:0] ctl_reg;
  logic [2:0] ien_reg;
  logic halt_reg;
  logic fresh_reg;
  // shadow of control, halt and irq enable writes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg <= CTRL_RST;
      ien_reg <= 3'h0;
      halt_reg <= HALT_RST;
      fresh_reg <= 1'b1;
    end else if (bus_i.wr) begin
      fresh_reg <= 1'b0;
      if (bus_i.addr == ADDR_CTRL) ctl_reg <= bus_i.wdata;
      if (bus_i.addr == ADDR_IRQ_EN) ien_reg <= bus_i.wdata[2:0];
      if (bus_i.addr == ADDR_HALT) halt_reg <= bus_i.wdata[0];
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start_low;
    !txd_o [*8];
  endsequence
  a_halt_quiet: assert property (
    halt_reg && $past(halt_reg) |-> txd_o && !sck_oe_o)
    else $error("line active while halted");
  a_txe_gated: assert property (
    !ctl_reg[CTRL_TX_EMPTY_IRQ_EN] && !$past(ctl_reg[CTRL_TX_EMPTY_IRQ_EN])
    |-> !tx_empty_irq_o)
    else $error("tx empty request without enable");
  a_rx_gated: assert property (
    !ctl_reg[CTRL_RX_IRQ_EN] && !$past(ctl_reg[CTRL_RX_IRQ_EN])
    |-> !rx_full_irq_o && !rx_error_irq_o)
    else $error("rx request without enable");
  a_irq_masked: assert property (
    ien_reg == 3'h0 && $past(ien_reg) == 3'h0 |-> !irq_o)
    else $error("irq while all masked");
  a_tx_off_idle: assert property (
    !ctl_reg[CTRL_TX_ON] && !$past(ctl_reg[CTRL_TX_ON]) |-> txd_o)
    else $error("tx line active while off");
  a_rx_off_still: assert property (
    !ctl_reg[CTRL_RX_ON] && !$past(ctl_reg[CTRL_RX_ON])
    && ctl_reg[CTRL_RX_IRQ_EN] && $past(ctl_reg[CTRL_RX_IRQ_EN])
    |-> !$rose(rx_full_irq_o))
    else $error("data received while rx off");
  a_sck_input: assert property (
    ctl_reg[1:0] != CKE_OUT && $past(ctl_reg[1:0]) != CKE_OUT
    |-> !sck_oe_o)
    else $error("clock pin driven");
  a_stat_reset: assert property (
    $past(bus_i.rd) && $past(bus_i.addr) == ADDR_STAT && $past(fresh_reg)
    |-> rd_data_o == STAT_RST)
    else $error("status reset value wrong");
  a_start_bit: assert property (
    $fell(txd_o) |-> s_start_low)
    else $error("start bit too short");
endmodule

bind asr_top asr_top_assertions i_asr_top_assertions (.sys_clk_i, .rst_i,
  .bus_i, .rd_data_o, .rxd_i, .txd_o, .sck_o, .sck_oe_o, .tx_empty_irq_o,
  .rx_full_irq_o, .rx_error_irq_o, .irq_o);

// *** test/asr_rtx.sv ***
// partner: remote line transmitter driving the receive pin
// assumes each frame starts just after a rising edge
`timescale 1ns/1ps
module asr_rtx (
  input wire logic sys_clk_i,
  output logic line_o
);
  initial line_o = 1'b1;
  task send(input logic [7:0] d, input logic stop_v, input int cpb);
    line_o <= 1'b0;
    repeat (cpb) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= d[i];
      repeat (cpb) @(posedge sys_clk_i);
    end
    line_o <= stop_v;
    repeat (cpb) @(posedge sys_clk_i);
    line_o <= 1'b1;
  endtask
endmodule

// *** test/tb_top.sv ***
// testbench: registers, reception, transmission, interrupts
// assumes asr_top and the line transmitter model
`timescale 1ns/1ps
module tb_top;
  import asr_pkg::*;
  typedef struct packed {
    logic [31:0] a;
    logic [7:0] d;
    logic w;
    logic [7:0] e;
  } asr_row_t;
  logic clk;
  logic rst;
  asr_bus_req_t bus;
  logic [7:0] rd_data;
  logic rxd, txd, sck, sck_oe, txe_irq, rxf_irq, rxe_irq, irq;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  logic [7:0] v;
  logic [8:0] fr;
  asr_row_t rows[10] = '{
    '{ADDR_STAT, 8'h00, 1'b0, 8'h84},
    '{ADDR_MODE, 8'h00, 1'b0, 8'h00},
    '{ADDR_CTRL, 8'h00, 1'b0, 8'h00},
    '{ADDR_BAUD, 8'h00, 1'b0, 8'hFF},
    '{ADDR_IRQ_CLR, 8'h00, 1'b0, 8'h00},
    '{32'hFFFE8014, 8'h5A, 1'b1, 8'h00},
    '{ADDR_RXD, 8'h33, 1'b1, 8'h00},
    '{ADDR_BAUD, 8'h01, 1'b1, 8'h01},
    '{ADDR_IRQ_EN, 8'h07, 1'b1, 8'h07},
    '{ADDR_HALT, 8'h00, 1'b1, 8'h00}};
  asr_top i_asr_top (.sys_clk_i(clk), .rst_i(rst), .bus_i(bus),
    .rd_data_o(rd_data), .rxd_i(rxd), .txd_o(txd), .sck_o(sck),
    .sck_oe_o(sck_oe), .tx_empty_irq_o(txe_irq), .rx_full_irq_o(rxf_irq),
    .rx_error_irq_o(rxe_irq), .irq_o(irq));
  asr_rtx i_asr_rtx (.sys_clk_i(clk), .line_o(rxd));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task wr(input logic [31:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [31:0] a);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = rd_data;
    @(posedge clk);
  endtask
  // wait up to lim cycles for a level, then compare
  task automatic wt(input string nm, ref logic s, input logic e, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (s !== e && n < lim);
    chk(nm, e, s);
    @(posedge clk);
  endtask
  task results;
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    results();
  end
  initial begin
    rst = 1'b1;
    bus = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("reg", rows[i].e, v);
    end
    wr(ADDR_HALT, 8'h01);
    wr(ADDR_CTRL, 8'h50);
    i_asr_rtx.send(8'hA5, 1'b1, 64);
    rd(ADDR_STAT);
    chk("halted status", 8'h84, v);
    wr(ADDR_HALT, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h50);
    i_asr_rtx.send(8'hA5, 1'b1, 64);
    wt("rx full irq", rxf_irq, 1'b1, 200);
    wt("irq", irq, 1'b1, 5);
    rd(ADDR_RXD);
    chk("rx data", 8'hA5, v);
    rd(ADDR_STAT);
    chk("status full", 8'hC4, v);
    i_asr_rtx.send(8'h3C, 1'b1, 64);
    wt("overrun irq", rxe_irq, 1'b1, 200);
    rd(ADDR_STAT);
    chk("status overrun", 8'hE4, v);
    rd(ADDR_RXD);
    chk("rx data kept", 8'hA5, v);
    wr(ADDR_CTRL, 8'h10);
    wt("rx full gated", rxf_irq, 1'b0, 3);
    wt("rx err gated", rxe_irq, 1'b0, 3);
    wr(ADDR_IRQ_EN, 8'h00);
    wt("irq masked", irq, 1'b0, 3);
    wr(ADDR_IRQ_EN, 8'h07);
    wt("irq unmasked", irq, 1'b1, 3);
    wr(ADDR_STAT, 8'h84);
    wr(ADDR_IRQ_CLR, 8'h07);
    wt("irq cleared", irq, 1'b0, 3);
    wr(ADDR_CTRL, 8'h50);
    i_asr_rtx.send(8'h00, 1'b0, 64);
    wt("break irq", rxe_irq, 1'b1, 200);
    rd(ADDR_STAT);
    chk("framing", 8'h10, v & 8'h10);
    wr(ADDR_STAT, 8'h84);
    wr(ADDR_MODE, 8'h20);
    i_asr_rtx.send(8'hA5, 1'b1, 64);
    repeat (100) @(posedge clk);
    rd(ADDR_STAT);
    chk("parity error", 8'h08, v & 8'h18);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_STAT, 8'h84);
    wr(ADDR_CTRL, 8'h40);
    i_asr_rtx.send(8'h5A, 1'b1, 64);
    rd(ADDR_STAT);
    chk("rx off status", 8'h84, v);
    wr(ADDR_BAUD, 8'h28);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_TXD, 8'h5A);
    n = 0;
    repeat (1500) begin
      @(negedge clk);
      if (txd !== 1'b1) n++;
    end
    chk("tx off line", 16'h0, n[15:0]);
    wt("tx empty off", txe_irq, 1'b0, 1);
    wr(ADDR_CTRL, 8'h20);
    wt("start bit", txd, 1'b0, 200);
    n = 0;
    while (txd === 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk("two low bits", 16'd2624, n[15:0]);
    chk("clock pin input", 16'h0, {15'h0, sck_oe});
    fr = {1'b1, 8'h5A};
    repeat (656) @(negedge clk);
    for (int i = 1; i < 9; i++) begin
      chk("tx bit", {15'h0, fr[i]}, {15'h0, txd});
      repeat (328) @(negedge clk);
      chk("bit clock", 16'h1, {15'h0, sck});
      repeat (984) @(negedge clk);
    end
    @(posedge clk);
    wr(ADDR_CTRL, 8'hA0);
    wt("tx empty on", txe_irq, 1'b1, 3);
    results();
  end
endmodule
